// File: tbc_time_base_ctrl.sv
// Time base control: APB registers, source select, LCD clock, tone pin and carrier.
//
// How it works
// - Tone pin is ordinary port until enabled.
// - Enabled, tone off: pin holds idle polarity.
// - Tone on: open-drain pin carries tone clock.
// - Tone: crystal 2048/4096 Hz, main /2048 or /1024.
// - Bit 7 picks source; 1 main, reset 0.
// - Bit 6 unused, always reads zero.
// - Crystal source: LCD clock /128 or /64.
// - Main source: LCD clock /16384 or /8192.
// - Duty bit gives 33% if bit3 clear.
// - Divider field sets carrier rate, resets zero.
`timescale 1ns/1ps
module tbc_time_base_ctrl #(
  parameter int LCD_MAIN_DIV_SLOW = 16384,
  parameter int LCD_MAIN_DIV_FAST = 8192
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [tbc_pkg::TBC_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic                          xtal_32k_i,
  input  wire logic                          gpio_dout_i,
  input  wire logic                          gpio_drive_i,
  input  wire logic                          tone_pin_i,
  output logic                               tone_pin_o,
  output logic                               tone_pin_oe_n_o,
  output logic                               tone_pin_in_o,
  output logic                               lcd_clock_en_o,
  output logic                               carrier_o
);
  import tbc_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [3:0]  tone;
    logic [31:0] rdata;
    logic [2:0]  xtal_sync;
    logic [1:0]  pin_sync;
    logic        pin_o;
    logic        pin_oe_n;
  } tbc_top_state_t;

  tbc_top_state_t st_ff;
  tbc_top_state_t nxt_st;

  logic                  src_main;
  logic                  xtal_tick;
  logic                  tb_tick;
  logic [TBC_TONE_W-1:0] tone_half_m1;
  logic [TBC_LCD_W-1:0]  lcd_half_m1;
  logic                  tone_level;
  logic                  lcd_level;
  logic                  access;
  logic                  setup;
  logic                  mapped;

  ////////////////////////////////////////////////////////////////////////////////

  // Returns true for any address the slave answers.
  function automatic logic addr_mapped(input logic [TBC_ADDR_W-1:0] a);
    if (a == TBC_ADDR_CTRL1) begin
      return 1'b1;
    end else if (a == TBC_ADDR_TONE) begin
      return 1'b1;
    end else if (a == TBC_ADDR_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Half period minus one, cut to the divider width.
  function automatic logic [TBC_LCD_W-1:0] half_m1(input int div);
    return TBC_LCD_W'(div / 2 - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  assign src_main  = st_ff.ctrl1[TBC_BIT_SRC_SEL];
  // The crystal is a foreign clock, so only its synchronised copy is edge-detected.
  assign xtal_tick = st_ff.xtal_sync[1] & ~st_ff.xtal_sync[2];
  // Main oscillator is the system clock itself; every cycle is a source tick.
  assign tb_tick   = src_main ? 1'b1 : xtal_tick;

  always_comb begin
    if (src_main) begin
      tone_half_m1 = st_ff.tone[TBC_BIT_TONE_FSEL]
                     ? TBC_TONE_W'(half_m1(TBC_TONE_MAIN_FAST))
                     : TBC_TONE_W'(half_m1(TBC_TONE_MAIN_SLOW));
      lcd_half_m1  = st_ff.ctrl1[TBC_BIT_LCD_SEL]
                     ? half_m1(LCD_MAIN_DIV_SLOW)
                     : half_m1(LCD_MAIN_DIV_FAST);
    end else begin
      tone_half_m1 = st_ff.tone[TBC_BIT_TONE_FSEL]
                     ? TBC_TONE_W'(half_m1(TBC_TONE_XTAL_FAST))
                     : TBC_TONE_W'(half_m1(TBC_TONE_XTAL_SLOW));
      lcd_half_m1  = st_ff.ctrl1[TBC_BIT_LCD_SEL]
                     ? half_m1(TBC_LCD_XTAL_SLOW)
                     : half_m1(TBC_LCD_XTAL_FAST);
    end
  end

  tbc_divider #(
    .W (TBC_TONE_W)
  ) u_tone_div (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tb_tick),
    .half_m1_i (tone_half_m1),
    .level_o   (tone_level),
    .period_o  ()
  );

  tbc_divider #(
    .W (TBC_LCD_W)
  ) u_lcd_div (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tb_tick),
    .half_m1_i (lcd_half_m1),
    .level_o   (lcd_level),
    .period_o  (lcd_clock_en_o)
  );

  // The carrier always counts the main oscillator, whatever the time-base source.
  tbc_carrier u_carrier (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (1'b1),
    .duty33_i  (st_ff.ctrl1[TBC_BIT_DUTY_SEL]),
    .div_sel_i (st_ff.ctrl1[TBC_DIV_MSB:TBC_DIV_LSB]),
    .carrier_o (carrier_o)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign setup     = psel_i & ~penable_i;
  assign access    = psel_i & penable_i;
  assign mapped    = addr_mapped(paddr_i);
  // Zero wait states: every access phase completes at its first edge.
  assign pready_o  = access;
  assign pslverr_o = access & ~mapped;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.xtal_sync = {st_ff.xtal_sync[1:0], xtal_32k_i};
    nxt_st.pin_sync  = {st_ff.pin_sync[0], tone_pin_i};

    // Read data is staged in the setup phase so it leaves a flip-flop.
    if (setup && !pwrite_i) begin
      if (paddr_i == TBC_ADDR_CTRL1) begin
        nxt_st.rdata = {24'h000000, st_ff.ctrl1 & TBC_CTRL1_WMASK};
      end else if (paddr_i == TBC_ADDR_TONE) begin
        nxt_st.rdata = {28'h0000000, st_ff.tone};
      end else if (paddr_i == TBC_ADDR_STATUS) begin
        nxt_st.rdata = 32'h00000000;
        nxt_st.rdata[TBC_BIT_ST_TONE] = tone_level;
        nxt_st.rdata[TBC_BIT_ST_CARR] = carrier_o;
        nxt_st.rdata[TBC_BIT_ST_LCD]  = lcd_level;
        nxt_st.rdata[TBC_BIT_ST_XTAL] = st_ff.xtal_sync[1];
      end else begin
        nxt_st.rdata = 32'h00000000;
      end
    end

    if (access && pwrite_i) begin
      if (paddr_i == TBC_ADDR_CTRL1) begin
        nxt_st.ctrl1 = pwdata_i[7:0] & TBC_CTRL1_WMASK;
      end else if (paddr_i == TBC_ADDR_TONE) begin
        nxt_st.tone = pwdata_i[3:0];
      end
    end

    // Pin mux; the tone driver is open drain, so it only ever pulls low.
    if (!st_ff.tone[TBC_BIT_TONE_PEN]) begin
      nxt_st.pin_o    = gpio_dout_i;
      nxt_st.pin_oe_n = ~gpio_drive_i;
    end else if (!st_ff.tone[TBC_BIT_TONE_ON]) begin
      nxt_st.pin_o    = 1'b0;
      nxt_st.pin_oe_n = st_ff.tone[TBC_BIT_TONE_POL];
    end else begin
      nxt_st.pin_o    = 1'b0;
      nxt_st.pin_oe_n = tone_level;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_ff <= '{ctrl1: TBC_CTRL1_RESET, tone: TBC_TONE_RESET, rdata: 32'h00000000,
                 xtal_sync: 3'h0, pin_sync: 2'h0, pin_o: 1'b0, pin_oe_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o        = st_ff.rdata;
  assign tone_pin_o      = st_ff.pin_o;
  assign tone_pin_oe_n_o = st_ff.pin_oe_n;
  assign tone_pin_in_o   = st_ff.pin_sync[1];

endmodule // tbc_time_base_ctrl

// File: tbc_pkg.sv
// Package with register map, field positions and divider constants of the time base block.
package tbc_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] TBC_ADDR_CTRL1  = 8'h10;
  localparam logic [7:0] TBC_ADDR_TONE   = 8'h14;
  localparam logic [7:0] TBC_ADDR_STATUS = 8'h18;
  localparam int         TBC_ADDR_W      = 8;

  // Field positions in time_base_control_1.
  localparam int TBC_BIT_SRC_SEL  = 7;
  localparam int TBC_BIT_RSVD6    = 6;
  localparam int TBC_BIT_LCD_SEL  = 5;
  localparam int TBC_BIT_DUTY_SEL = 4;
  localparam int TBC_DIV_MSB      = 3;
  localparam int TBC_DIV_LSB      = 0;
  localparam logic [7:0] TBC_CTRL1_RESET = 8'h00;
  localparam logic [7:0] TBC_CTRL1_WMASK = 8'hbf;

  // Field positions in the tone control register.
  localparam int TBC_BIT_TONE_ON   = 0;
  localparam int TBC_BIT_TONE_FSEL = 1;
  localparam int TBC_BIT_TONE_POL  = 2;
  localparam int TBC_BIT_TONE_PEN  = 3;
  localparam logic [3:0] TBC_TONE_RESET = 4'h0;

  // Field positions in the status register.
  localparam int TBC_BIT_ST_TONE  = 0;
  localparam int TBC_BIT_ST_CARR  = 1;
  localparam int TBC_BIT_ST_LCD   = 2;
  localparam int TBC_BIT_ST_XTAL  = 3;

  // Tone clock: full-period divisors of the time-base source.
  localparam int TBC_TONE_W         = 11;
  localparam int TBC_TONE_MAIN_SLOW = 2048;
  localparam int TBC_TONE_MAIN_FAST = 1024;
  localparam int TBC_XTAL_HZ        = 32768;
  localparam int TBC_TONE_XTAL_SLOW_HZ = 2048;
  localparam int TBC_TONE_XTAL_FAST_HZ = 4096;
  localparam int TBC_TONE_XTAL_SLOW = TBC_XTAL_HZ / TBC_TONE_XTAL_SLOW_HZ;
  localparam int TBC_TONE_XTAL_FAST = TBC_XTAL_HZ / TBC_TONE_XTAL_FAST_HZ;

  // LCD clock: divisors of the crystal source; main-source divisors are top parameters.
  localparam int TBC_LCD_W         = 13;
  localparam int TBC_LCD_XTAL_SLOW = 128;
  localparam int TBC_LCD_XTAL_FAST = 64;

  // Carrier: counter width, highest selection, base high times in source cycles.
  localparam int         TBC_CARR_W       = 8;
  localparam logic [3:0] TBC_CARR_SEL_MAX = 4'h5;
  localparam logic [7:0] TBC_CARR_HI50    = 8'h01;
  localparam logic [7:0] TBC_CARR_HI33    = 8'h02;
  localparam logic [7:0] TBC_CARR_PER50   = 8'h02;
  localparam logic [7:0] TBC_CARR_PER33   = 8'h06;

endpackage

// File: tbc_divider.sv
// Square wave divider stepped by a tick enable, with period-boundary reload.
`timescale 1ns/1ps
module tbc_divider #(
  parameter int W = 13
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] half_m1_i,
  output logic              level_o,
  output logic              period_o
);
  import tbc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] half;
    logic         level;
    logic         period;
  } tbc_div_state_t;

  tbc_div_state_t st_ff;
  tbc_div_state_t nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.period = 1'b0;
    if (tick_i) begin
      if (st_ff.cnt >= st_ff.half) begin
        nxt_st.cnt   = '0;
        nxt_st.level = ~st_ff.level;
        // A new rate is taken only when a full period ends, so no runt pulse appears.
        if (st_ff.level) begin
          nxt_st.half   = half_m1_i;
          nxt_st.period = 1'b1;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_ff <= '{cnt: '0, half: half_m1_i, level: 1'b0, period: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o  = st_ff.level;
  assign period_o = st_ff.period;

endmodule // tbc_divider

// File: tbc_carrier.sv
// Remote carrier generator with selectable divider and duty.
`timescale 1ns/1ps
module tbc_carrier (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       duty33_i,
  input  wire logic [3:0] div_sel_i,
  output logic            carrier_o
);
  import tbc_pkg::*;

  typedef struct packed {
    logic [TBC_CARR_W-1:0] cnt;
    logic [TBC_CARR_W-1:0] per;
    logic [TBC_CARR_W-1:0] hi;
    logic                  out;
  } tbc_carr_state_t;

  tbc_carr_state_t st_ff;
  tbc_carr_state_t nxt_st;
  logic [2:0]      sel;
  logic            use33;

  // Selections above the highest table entry clamp to it.
  always_comb begin
    sel   = (div_sel_i > TBC_CARR_SEL_MAX) ? TBC_CARR_SEL_MAX[2:0] : div_sel_i[2:0];
    // One-third duty is only honoured while the top divider bit is clear.
    use33 = duty33_i & ~div_sel_i[TBC_DIV_MSB];
  end

  always_comb begin
    nxt_st = st_ff;
    if (tick_i) begin
      if (st_ff.cnt >= st_ff.per - 1'b1) begin
        nxt_st.cnt = '0;
        // Settings are reloaded at the period boundary only.
        nxt_st.per = (use33 ? TBC_CARR_PER33 : TBC_CARR_PER50) << sel;
        nxt_st.hi  = (use33 ? TBC_CARR_HI33 : TBC_CARR_HI50) << sel;
        nxt_st.out = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.out = (st_ff.cnt + 1'b1) < st_ff.hi;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_ff <= '{cnt: '0, per: TBC_CARR_PER50, hi: TBC_CARR_HI50, out: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign carrier_o = st_ff.out;

endmodule // tbc_carrier

// File: tbc_monitor.sv
// Port checker for the time base block, bound into its top module.
`timescale 1ns/1ps
module tbc_monitor
  import tbc_pkg::*;
#(
  parameter int LCD_MAIN_DIV_SLOW = 16384,
  parameter int LCD_MAIN_DIV_FAST = 8192
) (
  input wire logic                          clock_i,
  input wire logic                          rst_n_i,
  input wire logic                          psel_i,
  input wire logic                          penable_i,
  input wire logic                          pwrite_i,
  input wire logic [tbc_pkg::TBC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]                   pwdata_i,
  input wire logic [31:0]                   prdata_o,
  input wire logic                          gpio_dout_i,
  input wire logic                          gpio_drive_i,
  input wire logic                          tone_pin_o,
  input wire logic                          tone_pin_oe_n_o,
  input wire logic                          lcd_clock_en_o,
  input wire logic                          carrier_o
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [3:0]  tone;
    logic        oe_q;
    logic [11:0] quiet;
    logic [15:0] lcd;
    logic [7:0]  hi;
    logic [11:0] tcnt;
  } tbc_mon_t;
  tbc_mon_t   st_ff;
  tbc_mon_t   nxt_st;
  logic       wr_acc;
  logic       rd_ctrl;
  logic       pen;
  logic       on;
  logic [3:0] sel;
  logic [7:0] hi_exp;
  assign wr_acc  = psel_i && penable_i && pwrite_i;
  assign rd_ctrl = psel_i && penable_i && !pwrite_i && paddr_i == TBC_ADDR_CTRL1;
  assign pen     = st_ff.tone[TBC_BIT_TONE_PEN];
  assign on      = st_ff.tone[TBC_BIT_TONE_ON];
  // Shadow registers and run-length counters; quiet counts cycles since any write.
  always_comb begin
    nxt_st = st_ff;
    if (wr_acc && paddr_i == TBC_ADDR_CTRL1) nxt_st.ctrl = pwdata_i[7:0] & 8'hbf;
    if (wr_acc && paddr_i == TBC_ADDR_TONE) nxt_st.tone = pwdata_i[3:0];
    nxt_st.quiet = wr_acc ? 12'h000 : st_ff.quiet + {11'h000, st_ff.quiet != 12'hfff};
    nxt_st.lcd = lcd_clock_en_o ? 16'h0000 : st_ff.lcd + 16'h0001;
    nxt_st.hi = carrier_o ? st_ff.hi + 8'h01 : 8'h00;
    nxt_st.oe_q = tone_pin_oe_n_o;
    nxt_st.tcnt = (pen && on && tone_pin_oe_n_o == st_ff.oe_q) ? st_ff.tcnt + 12'h001 : 12'h000;
    sel = (st_ff.ctrl[3:0] > TBC_CARR_SEL_MAX) ? TBC_CARR_SEL_MAX : st_ff.ctrl[3:0];
    hi_exp = ((st_ff.ctrl[4] && !st_ff.ctrl[3]) ? 8'h02 : 8'h01) << sel;
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end
  default clocking mon_cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_ctrl_readback: assert property (rd_ctrl |-> prdata_o == {24'h0, st_ff.ctrl})
    else $error("control register read mismatch");
  a_rsvd_zero: assert property (rd_ctrl |-> !prdata_o[TBC_BIT_RSVD6])
    else $error("reserved bit read as one");
  a_gpio_owns: assert property ($past(rst_n_i) && !$past(pen) |->
    tone_pin_oe_n_o == !$past(gpio_drive_i) && tone_pin_o == $past(gpio_dout_i))
    else $error("port data not on tone pin");
  a_idle_level: assert property ($past(rst_n_i) && $past(pen) && !$past(on) |->
    tone_pin_oe_n_o == $past(st_ff.tone[TBC_BIT_TONE_POL])) else $error("idle level wrong");
  a_drive_low: assert property ($past(rst_n_i) && $past(pen) |-> !tone_pin_o)
    else $error("tone pin driven high");
  a_tone_bound: assert property (st_ff.tcnt < 12'd1100)
    else $error("tone clock stalled");
  a_lcd_period: assert property (lcd_clock_en_o && st_ff.ctrl[7] &&
    st_ff.quiet > 2 * LCD_MAIN_DIV_SLOW + 256 |-> st_ff.lcd ==
    (st_ff.ctrl[5] ? LCD_MAIN_DIV_SLOW - 1 : LCD_MAIN_DIV_FAST - 1)) else $error("lcd period");
  a_carrier_high: assert property ($fell(carrier_o) && st_ff.quiet > 12'd450 |->
    st_ff.hi == hi_exp) else $error("carrier high time wrong");
endmodule // tbc_monitor
bind tbc_time_base_ctrl tbc_monitor #(
  .LCD_MAIN_DIV_SLOW(LCD_MAIN_DIV_SLOW),
  .LCD_MAIN_DIV_FAST(LCD_MAIN_DIV_FAST)
) tbc_monitor_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .gpio_dout_i(gpio_dout_i), .gpio_drive_i(gpio_drive_i), .tone_pin_o(tone_pin_o),
  .tone_pin_oe_n_o(tone_pin_oe_n_o), .lcd_clock_en_o(lcd_clock_en_o), .carrier_o(carrier_o)
);

// File: tbc_far_side.sv
// Far-side model: pulled-up tone pin with buzzer, LCD clock and carrier meters.
`timescale 1ns/1ps
module tbc_far_side (
  input  wire logic   clock_i,
  input  wire logic   pin_val_i,
  input  wire logic   pin_oe_n_i,
  input  wire logic   lcd_pulse_i,
  input  wire logic   carrier_i,
  output logic        pin_wire_o,
  output logic [15:0] tone_per_o,
  output logic [15:0] lcd_per_o,
  output logic [15:0] carr_hi_o,
  output logic [15:0] carr_per_o
);
  logic        w_q;
  logic        c_q;
  logic [15:0] t_cnt;
  logic [15:0] l_cnt;
  logic [15:0] h_cnt;
  logic [15:0] p_cnt;
  // A released pin is pulled up by the board, so it never keeps the last driven value.
  assign pin_wire_o = pin_oe_n_i ? 1'b1 : pin_val_i;
  always @(posedge clock_i) begin
    w_q <= pin_wire_o;
    c_q <= carrier_i;
    t_cnt <= (pin_wire_o && !w_q) ? 16'h0001 : t_cnt + 16'h0001;
    l_cnt <= lcd_pulse_i ? 16'h0001 : l_cnt + 16'h0001;
    h_cnt <= carrier_i ? h_cnt + 16'h0001 : 16'h0000;
    p_cnt <= (carrier_i && !c_q) ? 16'h0001 : p_cnt + 16'h0001;
    if (pin_wire_o && !w_q) tone_per_o <= t_cnt;
    if (lcd_pulse_i) lcd_per_o <= l_cnt;
    if (!carrier_i && c_q) carr_hi_o <= h_cnt;
    if (carrier_i && !c_q) carr_per_o <= p_cnt;
  end
endmodule // tbc_far_side

// File: tbc_time_base_ctrl_bench.sv
// Self-checking bench of the time base block with its far-side model.
`timescale 1ns/1ps
module tbc_time_base_ctrl_bench;
  import tbc_pkg::*;
  localparam int LSLOW = 32;
  localparam int LFAST = 16;
  localparam int XPER  = 20;
  logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, xtal_32k_i;
  logic        gpio_dout_i, gpio_drive_i, pready_o, pslverr_o, tone_pin_o, tone_pin_oe_n_o;
  logic        tone_pin_in_o, lcd_clock_en_o, carrier_o, pin_wire, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, v;
  logic [15:0] tone_per, lcd_per, carr_hi, carr_per;
  logic [4:0]  cv;
  int          n_fail, cmp_count;
  tbc_time_base_ctrl #(.LCD_MAIN_DIV_SLOW(LSLOW), .LCD_MAIN_DIV_FAST(LFAST)) tbc_time_base_ctrl_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .xtal_32k_i(xtal_32k_i),
    .gpio_dout_i(gpio_dout_i), .gpio_drive_i(gpio_drive_i), .tone_pin_i(pin_wire),
    .tone_pin_o(tone_pin_o), .tone_pin_oe_n_o(tone_pin_oe_n_o), .tone_pin_in_o(tone_pin_in_o),
    .lcd_clock_en_o(lcd_clock_en_o), .carrier_o(carrier_o));
  tbc_far_side tbc_far_side_i (.clock_i(clock_i), .pin_val_i(tone_pin_o),
    .pin_oe_n_i(tone_pin_oe_n_o), .lcd_pulse_i(lcd_clock_en_o), .carrier_i(carrier_o),
    .pin_wire_o(pin_wire), .tone_per_o(tone_per), .lcd_per_o(lcd_per), .carr_hi_o(carr_hi),
    .carr_per_o(carr_per));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // The crystal is offset in phase so its edges never meet the main clock edge.
  initial begin
    xtal_32k_i = 1'b0;
    #1.3;
    forever #50 xtal_32k_i = ~xtal_32k_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rd = prdata_o;
    err = pslverr_o;
    if (k >= 50) begin
      n_fail++;
      end_of_test();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic [31:0] tone_exp(input logic s, input logic f);
    return 32'(s ? (f ? TBC_TONE_MAIN_FAST : TBC_TONE_MAIN_SLOW)
                 : (f ? TBC_TONE_XTAL_FAST : TBC_TONE_XTAL_SLOW) * XPER);
  endfunction
  function automatic logic [31:0] lcd_exp(input logic s, input logic l);
    return 32'(s ? (l ? LSLOW : LFAST) : (l ? TBC_LCD_XTAL_SLOW : TBC_LCD_XTAL_FAST) * XPER);
  endfunction
  function automatic logic [31:0] carr_exp(input logic [4:0] c, input logic per);
    logic [3:0] s;
    s = (c[3:0] > 4'h5) ? 4'h5 : c[3:0];
    if (c[4] && !c[3]) return per ? 32'd6 << s : 32'd2 << s;
    return per ? 32'd2 << s : 32'd1 << s;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, gpio_dout_i, gpio_drive_i} = 6'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'habe62e3e));
    cyc(6);
    rst_n_i <= 1'b1;
    apb(1'b0, TBC_ADDR_CTRL1, 32'h0);
    check(rd, 32'h0, "control reset");
    apb(1'b0, TBC_ADDR_TONE, 32'h0);
    check(rd, 32'h0, "tone reset");
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, TBC_ADDR_STATUS, 32'h0);
    check(rd & 32'hfffffff0, 32'h0, "status unused bits");
    check({31'h0, err}, 32'h0, "status error");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hffffffff : $urandom;
      apb(1'b1, TBC_ADDR_CTRL1, v);
      apb(1'b0, TBC_ADDR_CTRL1, 32'h0);
      check(rd, {24'h0, v[7:0] & 8'hbf}, "control readback");
    end
    // A reset in mid-run also restarts the dividers that the random writes disturbed.
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      @(posedge clock_i);
      gpio_dout_i <= v[0];
      gpio_drive_i <= v[1];
      cyc(6);
      check({31'h0, pin_wire}, {31'h0, v[1] ? v[0] : 1'b1}, "port pin");
      check({31'h0, tone_pin_in_o}, {31'h0, v[1] ? v[0] : 1'b1}, "pin input");
    end
    for (int p = 0; p < 2; p++) begin
      gpio_dout_i <= !p[0];
      apb(1'b1, TBC_ADDR_TONE, {28'h0, 1'b1, p[0], 2'b00});
      cyc(4);
      check({31'h0, pin_wire}, {31'h0, p[0]}, "idle level");
    end
    for (int s = 0; s < 2; s++) begin
      for (int f = 0; f < 2; f++) begin
        apb(1'b1, TBC_ADDR_CTRL1, {24'h0, s[0], 1'b0, f[0], 5'h00});
        apb(1'b1, TBC_ADDR_TONE, {28'h0, 1'b1, 1'b0, f[0], 1'b1});
        cyc(3 * (tone_exp(s[0], f[0]) + lcd_exp(s[0], f[0])));
        check({16'h0, tone_per}, tone_exp(s[0], f[0]), "tone period");
        check({16'h0, lcd_per}, lcd_exp(s[0], f[0]), "lcd period");
      end
    end
    apb(1'b1, TBC_ADDR_TONE, 32'h0);
    for (int c = 0; c < 15; c++) begin
      v = $urandom;
      cv = (c < 12) ? {c[0], 4'(c >> 1)} : (c == 12) ? 5'h19 : (c == 13) ? 5'h0c : v[4:0];
      apb(1'b1, TBC_ADDR_CTRL1, {27'h0, cv});
      cyc(700);
      check({16'h0, carr_hi}, carr_exp(cv, 1'b0), "carrier high");
      check({16'h0, carr_per}, carr_exp(cv, 1'b1), "carrier period");
    end
    end_of_test();
  end
endmodule // tbc_time_base_ctrl_bench
